// *** pkg/cip_pkg.sv ***
`default_nettype none
package cip_pkg;
	localparam logic [7:0]  CMD_REQA      = 8'h26;
	localparam logic [7:0]  CMD_WUPA      = 8'h52;
	localparam logic [7:0]  CMD_CL1       = 8'h93;
	localparam logic [7:0]  CMD_CL2       = 8'h95;
	localparam logic [7:0]  NVB_ANTICOLL  = 8'h20;
	localparam logic [7:0]  NVB_SELECT    = 8'h70;
	localparam logic [7:0]  CMD_HALT      = 8'h50;
	localparam logic [7:0]  CMD_READ      = 8'h30;
	localparam logic [7:0]  CMD_SET_USAGE = 8'h40;
	localparam logic [7:0]  BLOCK0_ADDR   = 8'h00;
	localparam logic [7:0]  CASCADE_TAG   = 8'h88;
	localparam logic [7:0]  RND_ID_PREFIX = 8'h08;
	localparam logic [3:0]  NONUNIQ_NIB   = 4'hf;
	localparam logic [7:0]  USAGE_PLAIN   = 8'h00;
	localparam logic [7:0]  USAGE_SHORT   = 8'h40;
	localparam logic [7:0]  USAGE_RANDOM  = 8'h20;
	localparam logic [7:0]  USAGE_DERIVED = 8'h60;
	localparam logic [3:0]  CODE_ACK      = 4'ha;
	localparam logic [3:0]  CODE_NAK      = 4'h4;
	localparam logic [15:0] ATQA_VALUE    = 16'h0044;
	localparam logic [7:0]  SAK_CASCADE   = 8'h04;
	localparam logic [7:0]  SAK_DONE      = 8'h18;
	localparam logic [31:0] LFSR_SEED     = 32'h1234abcd;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned FDT_MIN_NS    = 91150;
	localparam int unsigned FDT_MIN_CYC   = (FDT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TIMEOUT_MS    = 10;
	localparam int unsigned TIMEOUT_CYC   = (TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
	localparam logic [1:0]  OP_SEQ1       = 2'h0;
	localparam logic [1:0]  OP_SEQ2       = 2'h1;
	localparam logic [1:0]  OP_SEQ3       = 2'h2;
	localparam logic [1:0]  OP_SET_USAGE  = 2'h3;

	typedef enum logic [1:0] {
		double_size_plain_mode,
		double_size_shortcut_mode,
		single_random_id_mode,
		single_derived_id_mode
	} cip_identifier_function_mode_t;

	localparam cip_identifier_function_mode_t MODE_RESET = double_size_plain_mode;

	function automatic logic [7:0] bcc_of(input logic [31:0] w);
		return w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
	endfunction
endpackage
`default_nettype wire

// *** pkg/cip_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface cip_link_if;
	logic       field_on;
	logic       req_valid;
	logic [7:0] req_data;
	logic       req_last;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       rsp_last;
	logic       rsp_nibble;

	modport card (input field_on, req_valid, req_data, req_last,
		output rsp_valid, rsp_data, rsp_last, rsp_nibble);
	modport reader (output field_on, req_valid, req_data, req_last,
		input rsp_valid, rsp_data, rsp_last, rsp_nibble);
endinterface
`default_nettype wire

// *** src/cip_card_end.sv ***
// Function
// - Identifier held in block 0, sector 0
// - Usage command: 40h, type, CRC; 4-bit answer
// - Type 00h/40h/20h/60h picks the mode
// - Delivered in plain double-size mode
// - Usage command only after sector 0 authentication
// - First accepted command locks; later ones NAK
// - New mode effective after unselect or field reset
// - Reply no earlier than n=9; reader waits 10 ms
// - Sequence one: CL1 anticollision/select, then CL2
// - Sequence two: plain block 0 read, no auth
// - Otherwise block 0 only encrypted after auth
// - Sequence three: single-size, CL1 select only
// - Mode limits which activation sequences work
// - Single modes show derived or random identifier
// - ATQA never depends on the mode
// - Reader authenticates with last cascade level bytes
// - Four-byte variant uses cascade level 1 only
// - Four-byte variant: full identifier feeds authentication
// - Reader should always send the usage command once
`timescale 1ns/10ps
`default_nettype none
module cip_card_end #(
	parameter int unsigned FDT_CYC   = cip_pkg::FDT_MIN_CYC,
	parameter bit          FOUR_BYTE = 1'b0
) (
	input  wire logic        i_core_clk,    // Core clock
	input  wire logic        i_rst,         // Synchronous reset, high
	cip_link_if.card         lnk,           // Frame link to reader
	input  wire logic [55:0] i_uid,         // Identifier of block 0, UID0 on top
	input  wire logic        i_sec0_auth,   // Authenticated to sector 0
	output logic [1:0]       o_mode,        // Mode in effect
	output logic             o_locked,      // Usage setting locked
	output logic             o_active,      // Card selected
	output logic             o_blk0_read,   // Block 0 read pulse
	output logic             o_blk0_plain   // That read goes out unencrypted
);
	typedef enum logic [2:0] {cs_idle, cs_ready1, cs_ready2, cs_active, cs_halt} cip_card_st_t;

	if (FDT_CYC < 1) begin : g_chk
		$error("FDT_CYC must be at least one");
	end

	function automatic logic [31:0] cl1_word(input cip_pkg::cip_identifier_function_mode_t m,
		input logic [55:0] u, input logic [31:0] rnd);
		logic [31:0] w;
		w = u[55:24] ^ {u[23:0], 8'h00};
		if (FOUR_BYTE)
			return u[55:24];
		case (m)
			cip_pkg::single_random_id_mode:  return rnd;
			cip_pkg::single_derived_id_mode: return {w[31:28], cip_pkg::NONUNIQ_NIB, w[23:0]};
			default:                          return {cip_pkg::CASCADE_TAG, u[55:32]};
		endcase
	endfunction
	cip_card_st_t                        st_q, st_d;
	cip_pkg::cip_identifier_function_mode_t stored_q, stored_d, mode_q, mode_d;
	logic        lock_q, lock_d, short_q, short_d;
	logic [31:0] rnd_id_q, rnd_id_d, lfsr_q, lfsr_d, wait_q, wait_d;
	logic [7:0]  rx_q [0:6];
	logic [7:0]  rx_d [0:6];
	logic [7:0]  tx_q [0:4];
	logic [7:0]  tx_d [0:4];
	logic [2:0]  rxn_q, rxn_d, txn_q, txn_d, txi_q, txi_d;
	logic        nib_q, nib_d, snd_q, snd_d;
	logic        rv_q, rv_d, rl_q, rl_d, rn_q, rn_d;
	logic [7:0]  rd_q, rd_d;
	logic        brd_q, brd_d, bpl_q, bpl_d, act_q, act_d;
	always_comb begin
		logic [2:0]  n;
		logic [31:0] w;
		logic        sel_ok;
		logic        reply;
		n      = rxn_q + 3'd1;
		w      = 32'h0;
		sel_ok = 1'b0;
		reply  = 1'b0;
		st_d = st_q;
		stored_d = stored_q;
		mode_d = mode_q;
		lock_d = lock_q;
		short_d = short_q;
		rnd_id_d = rnd_id_q;
		lfsr_d = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		rx_d = rx_q;
		tx_d = tx_q;
		rxn_d = rxn_q;
		txn_d = txn_q;
		txi_d = txi_q;
		nib_d = nib_q;
		snd_d = snd_q;
		wait_d = wait_q;
		rv_d = 1'b0;
		rl_d = 1'b0;
		rn_d = 1'b0;
		rd_d = rd_q;
		brd_d = 1'b0;
		bpl_d = bpl_q;
		if (snd_q && wait_q != 32'h0) begin
			wait_d = wait_q - 32'h1;
		end else if (snd_q) begin
			rv_d = 1'b1;
			rd_d = tx_q[txi_q];
			rn_d = nib_q;
			rl_d = (txi_q == txn_q - 3'd1);
			txi_d = txi_q + 3'd1;
			if (txi_q == txn_q - 3'd1)
				snd_d = 1'b0;
		end
		if (lnk.req_valid && !lnk.req_last && rxn_q != 3'd7) begin
			rx_d[rxn_q] = lnk.req_data;
			rxn_d = n;
		end
		if (lnk.req_valid && lnk.req_last) begin
			rx_d[rxn_q] = lnk.req_data;
			rxn_d = 3'd0;
			w = (st_q == cs_ready2) ? i_uid[31:0] : cl1_word(mode_q, i_uid, rnd_id_q);
			sel_ok = ({rx_d[2], rx_d[3], rx_d[4], rx_d[5]} == w) && rx_d[6] == cip_pkg::bcc_of(w);
			reply = 1'b1;
			nib_d = 1'b0;
			txn_d = 3'd1;
			if ((rx_d[0] == cip_pkg::CMD_REQA && st_q == cs_idle) ||
				(rx_d[0] == cip_pkg::CMD_WUPA && (st_q == cs_idle || st_q == cs_halt))) begin
				st_d = cs_ready1;
				rnd_id_d = {cip_pkg::RND_ID_PREFIX, lfsr_q[23:0]};
				tx_d[0] = cip_pkg::ATQA_VALUE[7:0];
				tx_d[1] = cip_pkg::ATQA_VALUE[15:8];
				txn_d = 3'd2;
			end else if (n == 3'd2 && rx_d[1] == cip_pkg::NVB_ANTICOLL &&
				((st_q == cs_ready1 && rx_d[0] == cip_pkg::CMD_CL1) ||
				(st_q == cs_ready2 && rx_d[0] == cip_pkg::CMD_CL2))) begin
				{tx_d[0], tx_d[1], tx_d[2], tx_d[3]} = w;
				tx_d[4] = cip_pkg::bcc_of(w);
				txn_d = 3'd5;
			end else if (st_q == cs_ready1 && n == 3'd7 && rx_d[0] == cip_pkg::CMD_CL1 &&
				rx_d[1] == cip_pkg::NVB_SELECT && sel_ok) begin
				if (FOUR_BYTE || mode_q == cip_pkg::single_random_id_mode ||
					mode_q == cip_pkg::single_derived_id_mode) begin
					st_d = cs_active;
					tx_d[0] = cip_pkg::SAK_DONE;
				end else begin
					st_d = cs_ready2;
					short_d = (mode_q == cip_pkg::double_size_shortcut_mode);
					tx_d[0] = cip_pkg::SAK_CASCADE;
				end
			end else if (st_q == cs_ready2 && n == 3'd7 && rx_d[0] == cip_pkg::CMD_CL2 &&
				rx_d[1] == cip_pkg::NVB_SELECT && sel_ok) begin
				st_d = cs_active;
				short_d = 1'b0;
				tx_d[0] = cip_pkg::SAK_DONE;
			end else if (st_q == cs_ready2 && short_q && n == 3'd2 &&
				rx_d[0] == cip_pkg::CMD_READ && rx_d[1] == cip_pkg::BLOCK0_ADDR) begin
				st_d = cs_active;
				short_d = 1'b0;
				brd_d = 1'b1;
				bpl_d = 1'b1;
				{tx_d[0], tx_d[1], tx_d[2], tx_d[3], tx_d[4]} = i_uid[55:16];
				txn_d = 3'd5;
			end else if (st_q == cs_active && n == 3'd2 && rx_d[0] == cip_pkg::CMD_READ &&
				rx_d[1] == cip_pkg::BLOCK0_ADDR) begin
				// Encrypted data path lies outside; only NAK is answered here
				reply = !i_sec0_auth;
				brd_d = i_sec0_auth;
				bpl_d = 1'b0;
				nib_d = 1'b1;
				tx_d[0] = {4'h0, cip_pkg::CODE_NAK};
			end else if (st_q == cs_active && n == 3'd2 && rx_d[0] == cip_pkg::CMD_SET_USAGE) begin
				nib_d = 1'b1;
				tx_d[0] = {4'h0, cip_pkg::CODE_NAK};
				if (i_sec0_auth && !lock_q && !FOUR_BYTE) begin
					tx_d[0] = {4'h0, cip_pkg::CODE_ACK};
					lock_d = 1'b1;
					case (rx_d[1])
						cip_pkg::USAGE_PLAIN:   stored_d = cip_pkg::double_size_plain_mode;
						cip_pkg::USAGE_SHORT:   stored_d = cip_pkg::double_size_shortcut_mode;
						cip_pkg::USAGE_RANDOM:  stored_d = cip_pkg::single_random_id_mode;
						cip_pkg::USAGE_DERIVED: stored_d = cip_pkg::single_derived_id_mode;
						default: begin
							lock_d = 1'b0;
							tx_d[0] = {4'h0, cip_pkg::CODE_NAK};
						end
					endcase
				end
			end else if (st_q == cs_active && n == 3'd2 && rx_d[0] == cip_pkg::CMD_HALT &&
				rx_d[1] == 8'h00) begin
				st_d = cs_halt;
				mode_d = stored_q;
				reply = 1'b0;
			end else begin
				// An unexpected frame drops any card that is not halted back to idle without answering
				reply = 1'b0;
				short_d = 1'b0;
				if (st_q != cs_halt)
					st_d = cs_idle;
				if (st_q == cs_active || st_q == cs_ready2)
					mode_d = stored_q;
			end
			if (reply) begin
				snd_d = 1'b1;
				txi_d = 3'd0;
				wait_d = 32'(FDT_CYC - 1);
			end
		end
		if (!lnk.field_on) begin
			st_d = cs_idle;
			mode_d = stored_q;
			short_d = 1'b0;
			snd_d = 1'b0;
			// Field loss also silences an answer byte already on its way
			rv_d = 1'b0;
			rxn_d = 3'd0;
		end
		act_d = (st_d == cs_active);
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_q <= cs_idle;
			stored_q <= cip_pkg::MODE_RESET;
			mode_q <= cip_pkg::MODE_RESET;
			lock_q <= 1'b0;
			short_q <= 1'b0;
			rnd_id_q <= 32'h0;
			lfsr_q <= cip_pkg::LFSR_SEED;
			for (int i = 0; i < 7; i++)
				rx_q[i] <= 8'h00;
			for (int i = 0; i < 5; i++)
				tx_q[i] <= 8'h00;
			rxn_q <= 3'd0;
			txn_q <= 3'd0;
			txi_q <= 3'd0;
			nib_q <= 1'b0;
			snd_q <= 1'b0;
			wait_q <= 32'h0;
			rv_q <= 1'b0;
			rl_q <= 1'b0;
			rn_q <= 1'b0;
			rd_q <= 8'h00;
			brd_q <= 1'b0;
			bpl_q <= 1'b0;
			act_q <= 1'b0;
		end else begin
			st_q <= st_d;
			stored_q <= stored_d;
			mode_q <= mode_d;
			lock_q <= lock_d;
			short_q <= short_d;
			rnd_id_q <= rnd_id_d;
			lfsr_q <= lfsr_d;
			rx_q <= rx_d;
			tx_q <= tx_d;
			rxn_q <= rxn_d;
			txn_q <= txn_d;
			txi_q <= txi_d;
			nib_q <= nib_d;
			snd_q <= snd_d;
			wait_q <= wait_d;
			rv_q <= rv_d;
			rl_q <= rl_d;
			rn_q <= rn_d;
			rd_q <= rd_d;
			brd_q <= brd_d;
			bpl_q <= bpl_d;
			act_q <= act_d;
		end
	end
	assign lnk.rsp_valid  = rv_q;
	assign lnk.rsp_data   = rd_q;
	assign lnk.rsp_last   = rl_q;
	assign lnk.rsp_nibble = rn_q;
	assign o_mode         = mode_q;
	assign o_locked       = lock_q;
	assign o_active       = act_q;
	assign o_blk0_read    = brd_q;
	assign o_blk0_plain   = bpl_q;
endmodule
`default_nettype wire

// *** src/cip_reader_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module cip_reader_end #(
	parameter int unsigned TIMEOUT_CYC = cip_pkg::TIMEOUT_CYC
) (
	input  wire logic        i_core_clk,   // Core clock
	input  wire logic        i_rst,        // Synchronous reset, high
	cip_link_if.reader       lnk,          // Frame link to card
	input  wire logic        i_field_en,   // Keep the field on
	input  wire logic        i_start,      // Start an operation
	input  wire logic [1:0]  i_op,         // Operation code
	input  wire logic [7:0]  i_usage,      // Usage type to write
	input  wire logic        i_sec0_auth,  // Sector 0 authentication done
	output logic             o_busy,       // Operation running
	output logic             o_done,       // Operation finished pulse
	output logic             o_ok,         // Last operation succeeded
	output logic [3:0]       o_code,       // Last 4-bit answer
	output logic [31:0]      o_auth_uid    // Bytes for authentication
);
	typedef enum logic [1:0] {rs_idle, rs_send, rs_wait} cip_rd_st_t;

	if (TIMEOUT_CYC < 1) begin : g_chk
		$error("TIMEOUT_CYC must be at least one");
	end

	function automatic logic [2:0] last_step(input logic [1:0] op);
		case (op)
			cip_pkg::OP_SEQ1: return 3'd4;
			cip_pkg::OP_SEQ2: return 3'd3;
			cip_pkg::OP_SEQ3: return 3'd2;
			default:          return 3'd0;
		endcase
	endfunction

	function automatic logic [7:0] frame_byte(input logic [1:0] op, input logic [2:0] step,
		input logic [2:0] idx, input logic [7:0] usage, input logic [31:0] cl1, input logic [31:0] cl2);
		logic [31:0] w;
		logic [7:0]  b [0:6];
		w = (step == 3'd2) ? cl1 : cl2;
		b[0] = (step == 3'd2) ? cip_pkg::CMD_CL1 : cip_pkg::CMD_CL2;
		b[1] = cip_pkg::NVB_SELECT;
		{b[2], b[3], b[4], b[5]} = w;
		b[6] = cip_pkg::bcc_of(w);
		if (op == cip_pkg::OP_SET_USAGE)
			return (idx == 3'd0) ? cip_pkg::CMD_SET_USAGE : usage;
		case (step)
			3'd0:    return cip_pkg::CMD_REQA;
			3'd1:    return (idx == 3'd0) ? cip_pkg::CMD_CL1 : cip_pkg::NVB_ANTICOLL;
			3'd3: begin
				if (op == cip_pkg::OP_SEQ2)
					return (idx == 3'd0) ? cip_pkg::CMD_READ : cip_pkg::BLOCK0_ADDR;
				return (idx == 3'd0) ? cip_pkg::CMD_CL2 : cip_pkg::NVB_ANTICOLL;
			end
			default: return b[idx];
		endcase
	endfunction

	cip_rd_st_t  st_q, st_d;
	logic [1:0]  op_q, op_d;
	logic [7:0]  usage_q, usage_d;
	logic [2:0]  step_q, step_d, idx_q, idx_d, rbn_q, rbn_d;
	logic [31:0] tmo_q, tmo_d, cl1_q, cl1_d, cl2_q, cl2_d, auid_q, auid_d;
	logic [7:0]  rb_q [0:3];
	logic [7:0]  rb_d [0:3];
	logic        fld_q, fld_d, rv_q, rv_d, rl_q, rl_d, busy_q, busy_d, done_q, done_d, ok_q, ok_d;
	logic [7:0]  rd_q, rd_d;
	logic [3:0]  code_q, code_d;

	always_comb begin
		logic [2:0] flen;
		flen = (op_q == cip_pkg::OP_SET_USAGE || step_q == 3'd1 || step_q == 3'd3) ? 3'd2 :
			(step_q == 3'd0) ? 3'd1 : 3'd7;
		st_d = st_q;
		op_d = op_q;
		usage_d = usage_q;
		step_d = step_q;
		idx_d = idx_q;
		rbn_d = rbn_q;
		tmo_d = tmo_q;
		cl1_d = cl1_q;
		cl2_d = cl2_q;
		auid_d = auid_q;
		rb_d = rb_q;
		fld_d = i_field_en;
		rv_d = 1'b0;
		rl_d = 1'b0;
		rd_d = rd_q;
		busy_d = busy_q;
		done_d = 1'b0;
		ok_d = ok_q;
		code_d = code_q;
		case (st_q)
			rs_idle: begin
				if (i_start) begin
					op_d = i_op;
					usage_d = i_usage;
					step_d = 3'd0;
					idx_d = 3'd0;
					if (i_op == cip_pkg::OP_SET_USAGE && !i_sec0_auth) begin
						done_d = 1'b1;
						ok_d = 1'b0;
					end else begin
						st_d = rs_send;
						busy_d = 1'b1;
					end
				end
			end
			rs_send: begin
				rv_d = 1'b1;
				rd_d = frame_byte(op_q, step_q, idx_q, usage_q, cl1_q, cl2_q);
				rl_d = (idx_q == flen - 3'd1);
				idx_d = idx_q + 3'd1;
				if (idx_q == flen - 3'd1) begin
					st_d = rs_wait;
					rbn_d = 3'd0;
					tmo_d = 32'(TIMEOUT_CYC - 1);
				end
			end
			rs_wait: begin
				tmo_d = tmo_q - 32'h1;
				if (lnk.rsp_valid && rbn_q != 3'd4) begin
					rb_d[rbn_q[1:0]] = lnk.rsp_data;
					rbn_d = rbn_q + 3'd1;
				end
				if (lnk.rsp_valid && lnk.rsp_last) begin
					if (step_q == 3'd1)
						cl1_d = {rb_q[0], rb_q[1], rb_q[2], rb_q[3]};
					if (step_q == 3'd3 && op_q == cip_pkg::OP_SEQ1)
						cl2_d = {rb_q[0], rb_q[1], rb_q[2], rb_q[3]};
					if (lnk.rsp_nibble)
						code_d = lnk.rsp_data[3:0];
					if (lnk.rsp_nibble || step_q == last_step(op_q)) begin
						st_d = rs_idle;
						busy_d = 1'b0;
						done_d = 1'b1;
						// A select that still asks for another cascade level has not activated the card
						ok_d = lnk.rsp_nibble ? (lnk.rsp_data[3:0] == cip_pkg::CODE_ACK) :
							(op_q == cip_pkg::OP_SEQ2 || lnk.rsp_data == cip_pkg::SAK_DONE);
						auid_d = (op_q == cip_pkg::OP_SEQ1) ? cl2_d : cl1_d;
					end else begin
						st_d = rs_send;
						step_d = step_q + 3'd1;
						idx_d = 3'd0;
					end
				end else if (tmo_q == 32'h0) begin
					st_d = rs_idle;
					busy_d = 1'b0;
					done_d = 1'b1;
					ok_d = 1'b0;
					code_d = 4'h0;
				end
			end
			default: st_d = rs_idle;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_q <= rs_idle;
			op_q <= 2'h0;
			usage_q <= 8'h00;
			step_q <= 3'd0;
			idx_q <= 3'd0;
			rbn_q <= 3'd0;
			tmo_q <= 32'h0;
			cl1_q <= 32'h0;
			cl2_q <= 32'h0;
			auid_q <= 32'h0;
			for (int i = 0; i < 4; i++)
				rb_q[i] <= 8'h00;
			fld_q <= 1'b0;
			rv_q <= 1'b0;
			rl_q <= 1'b0;
			rd_q <= 8'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			ok_q <= 1'b0;
			code_q <= 4'h0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			usage_q <= usage_d;
			step_q <= step_d;
			idx_q <= idx_d;
			rbn_q <= rbn_d;
			tmo_q <= tmo_d;
			cl1_q <= cl1_d;
			cl2_q <= cl2_d;
			auid_q <= auid_d;
			rb_q <= rb_d;
			fld_q <= fld_d;
			rv_q <= rv_d;
			rl_q <= rl_d;
			rd_q <= rd_d;
			busy_q <= busy_d;
			done_q <= done_d;
			ok_q <= ok_d;
			code_q <= code_d;
		end
	end

	assign lnk.field_on  = fld_q;
	assign lnk.req_valid = rv_q;
	assign lnk.req_data  = rd_q;
	assign lnk.req_last  = rl_q;
	assign o_busy        = busy_q;
	assign o_done        = done_q;
	assign o_ok          = ok_q;
	assign o_code        = code_q;
	assign o_auth_uid    = auid_q;
endmodule
`default_nettype wire

// *** sim/cip_link_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module cip_link_assertions #(
	parameter int FDT_CYC = 8
) (
	input  wire logic       i_core_clk,  // Core clock
	input  wire logic       i_rst,       // Synchronous reset, high
	input  wire logic       field_on,    // Field present
	input  wire logic       req_valid,   // Request byte valid
	input  wire logic [7:0] req_data,    // Request byte
	input  wire logic       req_last,    // Last request byte
	input  wire logic       rsp_valid,   // Answer byte valid
	input  wire logic [7:0] rsp_data,    // Answer byte
	input  wire logic       rsp_last,    // Last answer byte
	input  wire logic       rsp_nibble   // 4-bit answer
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	a_atqa_low_byte: assert property (!req_valid ##1 (req_valid && req_last && req_data == cip_pkg::CMD_REQA) |->
		##(FDT_CYC + 1) rsp_valid && rsp_data == cip_pkg::ATQA_VALUE[7:0])
		else $error("answer to request low byte wrong");
	a_atqa_high_byte: assert property (!req_valid ##1 (req_valid && req_last && req_data == cip_pkg::CMD_REQA) |->
		##(FDT_CYC + 2) rsp_valid && rsp_last && rsp_data == cip_pkg::ATQA_VALUE[15:8])
		else $error("answer to request high byte wrong");
	a_reply_not_early: assert property (req_valid && req_last |=> !rsp_valid [*7])
		else $error("card answered before the frame delay");
	a_nibble_code: assert property (rsp_valid && rsp_nibble |-> rsp_last && (rsp_data == 8'h0a || rsp_data == 8'h04))
		else $error("4-bit answer is not a single ACK or NAK");
	a_usage_nibble: assert property (!req_valid ##1 (req_valid && !req_last && req_data == cip_pkg::CMD_SET_USAGE)
		##1 (req_valid && req_last) |-> ##(FDT_CYC + 1) rsp_valid && rsp_nibble)
		else $error("usage command not answered with a 4-bit code");
	a_field_quiet: assert property (!field_on |=> !rsp_valid)
		else $error("card answered with the field off");
	a_last_ends: assert property (rsp_valid && rsp_last |=> !rsp_valid)
		else $error("answer continued after its last byte");
	a_cl1_five_bytes: assert property (!req_valid ##1 (req_valid && req_data == cip_pkg::CMD_CL1)
		##1 (req_valid && req_last && req_data == cip_pkg::NVB_ANTICOLL) |->
		##(FDT_CYC + 1) (rsp_valid && !rsp_last) [*4] ##1 (rsp_valid && rsp_last))
		else $error("cascade level 1 answer is not five bytes");
	a_cl2_sak_done: assert property ((req_valid && req_data == cip_pkg::CMD_CL2)
		##1 (req_valid && req_data == cip_pkg::NVB_SELECT) ##5 (req_valid && req_last) |->
		##(FDT_CYC + 1) rsp_valid && rsp_last && rsp_data == cip_pkg::SAK_DONE)
		else $error("select of cascade level 2 did not complete");
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam logic [55:0] UID = 56'h11223344556677;
	logic        i_core_clk = 1'b0;
	logic        i_rst      = 1'b1;
	logic        field_en   = 1'b1;
	logic        start      = 1'b0;
	logic [1:0]  op         = 2'h0;
	logic [7:0]  usage      = 8'h00;
	logic        card_auth  = 1'b0;
	logic        rdr_auth   = 1'b0;
	logic [1:0]  mode;
	logic        locked;
	logic        blk0_read;
	logic        blk0_plain;
	logic        active;
	logic        busy;
	logic        done;
	logic        ok;
	logic [3:0]  code;
	logic [31:0] auth_uid;
	logic        plain_seen = 1'b0;
	int          n_mismatch  = 0;
	int          comparisons = 0;

	cip_link_if lnk_if ();
	cip_card_end #(.FDT_CYC(8), .FOUR_BYTE(1'b0)) u_cip_card_end (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.lnk(lnk_if), .i_uid(UID), .i_sec0_auth(card_auth), .o_mode(mode), .o_locked(locked),
		.o_active(active), .o_blk0_read(blk0_read), .o_blk0_plain(blk0_plain));
	cip_reader_end #(.TIMEOUT_CYC(64)) u_cip_reader_end (.i_core_clk(i_core_clk), .i_rst(i_rst), .lnk(lnk_if),
		.i_field_en(field_en), .i_start(start), .i_op(op), .i_usage(usage), .i_sec0_auth(rdr_auth),
		.o_busy(busy), .o_done(done), .o_ok(ok), .o_code(code), .o_auth_uid(auth_uid));
	cip_link_assertions #(.FDT_CYC(8)) u_cip_link_assertions (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.field_on(lnk_if.field_on), .req_valid(lnk_if.req_valid), .req_data(lnk_if.req_data),
		.req_last(lnk_if.req_last), .rsp_valid(lnk_if.rsp_valid), .rsp_data(lnk_if.rsp_data),
		.rsp_last(lnk_if.rsp_last), .rsp_nibble(lnk_if.rsp_nibble));

	initial begin
		forever #2.5 i_core_clk = ~i_core_clk;
	end

	// Latch the kind of the last block 0 read so a scenario can judge it later
	always @(posedge i_core_clk) begin
		if (blk0_read === 1'b1) begin
			plain_seen <= blk0_plain;
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge i_core_clk);
		#1 i_rst = 1'b1;
		repeat (20) @(posedge i_core_clk);
		#1 i_rst = 1'b0;
	endtask

	// Activation sequences start from idle, so the field is dropped first
	task automatic run_op(input logic [1:0] o, input logic [7:0] u);
		int n;
		if (o != cip_pkg::OP_SET_USAGE) begin
			@(posedge i_core_clk);
			#1 field_en = 1'b0;
			repeat (4) @(posedge i_core_clk);
			#1 field_en = 1'b1;
			repeat (4) @(posedge i_core_clk);
		end
		@(posedge i_core_clk);
		#1 start = 1'b1;
		op = o;
		usage = u;
		@(posedge i_core_clk);
		#1 start = 1'b0;
		// A refused request finishes on the edge that takes it, so look before waiting
		for (n = 0; n < 500; n++) begin
			if (done === 1'b1) break;
			@(posedge i_core_clk);
			#1;
		end
		if (n == 500) chk("done", 1, 0);
		chk("busy", 0, busy);
	endtask

	task automatic t_defaults();
		chk("mode", 0, mode);
		chk("locked", 0, locked);
		run_op(cip_pkg::OP_SEQ2, 8'h00);
		chk("seq2 ok", 0, ok);
		run_op(cip_pkg::OP_SEQ3, 8'h00);
		chk("seq3 ok", 0, ok);
		chk("seq3 active", 0, active);
		run_op(cip_pkg::OP_SEQ1, 8'h00);
		chk("seq1 ok", 1, ok);
		chk("seq1 active", 1, active);
		chk("seq1 auth", 32'h44556677, auth_uid);
		$display("test defaults done");
	endtask

	task automatic t_personal();
		run_op(cip_pkg::OP_SET_USAGE, 8'h40);
		chk("no auth reader", 0, ok);
		rdr_auth = 1'b1;
		run_op(cip_pkg::OP_SET_USAGE, 8'h40);
		chk("no auth card", 4'h4, code);
		chk("locked", 0, locked);
		card_auth = 1'b1;
		run_op(cip_pkg::OP_SET_USAGE, 8'h11);
		chk("bad type", 4'h4, code);
		chk("locked", 0, locked);
		run_op(cip_pkg::OP_SET_USAGE, 8'h40);
		chk("accept", 4'ha, code);
		chk("locked", 1, locked);
		chk("mode", 0, mode);
		run_op(cip_pkg::OP_SET_USAGE, 8'h00);
		chk("relock", 4'h4, code);
		card_auth = 1'b0;
		rdr_auth = 1'b0;
		run_op(cip_pkg::OP_SEQ2, 8'h00);
		chk("mode", 1, mode);
		chk("seq2 ok", 1, ok);
		chk("seq2 auth", 32'h88112233, auth_uid);
		chk("plain read", 1, plain_seen);
		run_op(cip_pkg::OP_SEQ1, 8'h00);
		chk("seq1 ok", 1, ok);
		$display("test personalization done");
	endtask

	task automatic t_single(input logic [7:0] u, input logic [1:0] m);
		do_reset();
		run_op(cip_pkg::OP_SEQ1, 8'h00);
		card_auth = 1'b1;
		rdr_auth = 1'b1;
		run_op(cip_pkg::OP_SET_USAGE, u);
		card_auth = 1'b0;
		rdr_auth = 1'b0;
		chk("accept", 4'ha, code);
		run_op(cip_pkg::OP_SEQ1, 8'h00);
		chk("mode", m, mode);
		chk("seq1 ok", 0, ok);
		chk("timeout code", 0, code);
		chk("seq1 active", 0, active);
		run_op(cip_pkg::OP_SEQ3, 8'h00);
		chk("seq3 ok", 1, ok);
		chk("seq3 active", 1, active);
		if (m == 2'h3) chk("derived id", 32'h4f444444, auth_uid);
		else chk("random prefix", 8'h08, auth_uid[31:24]);
		$display("test single mode done");
	endtask

	// The whole regression needs well under two thousand cycles; this leaves ample room
	initial begin
		repeat (20000) @(posedge i_core_clk);
		n_mismatch++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge i_core_clk);
		#1 i_rst = 1'b0;
		t_defaults();
		t_personal();
		t_single(8'h60, 2'h3);
		t_single(8'h20, 2'h2);
		end_sim();
	end
endmodule
`default_nettype wire
